/* hw/bbx_exec.sv */
// bbx_exec: execution of bit clear/set, bit test skip and relative branches
// assumes decode presents one operation per accept with ready high
// and the program counter stage applies pcLoad/pcTarget and discardNext
`timescale 1ns/100ps
module bbx_exec #(
  parameter int PC_WIDTH = bbx_pkg::PC_W
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic opValid,
  input wire logic [bbx_pkg::OP_W-1:0] opKind,
  input wire logic [bbx_pkg::FILE_AW-1:0] fileAddr,
  input wire logic [bbx_pkg::BIT_W-1:0] bitSel,
  input wire logic [bbx_pkg::LIT_W-1:0] branchLit,
  input wire logic [bbx_pkg::DATA_W-1:0] wreg,
  input wire logic [PC_WIDTH-1:0] pcNext,
  input wire logic [bbx_pkg::FILE_AW-1:0] peekAddr,
  output logic ready,
  output logic pcLoad,
  output logic [PC_WIDTH-1:0] pcTarget,
  output logic discardNext,
  output logic statusWrEn,
  output logic [bbx_pkg::DATA_W-1:0] peekData
);
  bbx_mem_if memBus ();

  bbx_pkg::bbx_state_e state;
  bbx_pkg::bbx_state_e next_state;
  logic [bbx_pkg::OP_W-1:0] curOp;
  logic [bbx_pkg::OP_W-1:0] next_curOp;
  logic [bbx_pkg::FILE_AW-1:0] curAddr;
  logic [bbx_pkg::FILE_AW-1:0] next_curAddr;
  logic [bbx_pkg::BIT_W-1:0] curBit;
  logic [bbx_pkg::BIT_W-1:0] next_curBit;
  logic [PC_WIDTH-1:0] target;
  logic [PC_WIDTH-1:0] next_target;
  logic next_ready;
  logic next_pcLoad;
  logic [PC_WIDTH-1:0] next_pcTarget;
  logic next_discardNext;
  logic [bbx_pkg::DATA_W-1:0] next_peekData;
  logic [PC_WIDTH-1:0] litExt;
  logic [PC_WIDTH-1:0] wregExt;
  logic testedBit;
  logic [bbx_pkg::DATA_W-1:0] bitMask;
  logic accept;

  // offsets are extended to the pc width, so it must be strictly wider
  if (PC_WIDTH <= bbx_pkg::LIT_W || PC_WIDTH <= bbx_pkg::DATA_W)
  begin : gWidthCheck
    $error("bbx_exec: program counter not wider than branch offset");
  end

  // the two-state sequencer serves exactly two cycles per operation
  if (bbx_pkg::EXEC_CYCLES != 2)
  begin : gCycleCheck
    $error("bbx_exec: sequencer serves two-cycle operations only");
  end

  // storage has no reset: a bit op on an unwritten word leaves its other bits unknown
  bbx_regfile #(
    .DEPTH(bbx_pkg::FILE_DEPTH)
  ) fileMem (
    .clock(clock),
    .port(memBus.mem)
  );

  // a request seen while busy is dropped, not queued
  assign accept = opValid && ready && (state == bbx_pkg::ST_IDLE);
  assign litExt = {{(PC_WIDTH - bbx_pkg::LIT_W){branchLit[bbx_pkg::LIT_W-1]}}, branchLit};
  assign wregExt = {{(PC_WIDTH - bbx_pkg::DATA_W){1'b0}}, wreg};

  // one-hot mask of the operand bit, shared by modify and test paths
  for (genvar i = 0; i < bbx_pkg::DATA_W; i++)
  begin : gBitMask
    assign bitMask[i] = (32'(curBit) == i);
  end

  assign testedBit = |(memBus.rdData & bitMask);

  // read port: the operand while accepting, otherwise the observation address
  assign memBus.rdAddr = accept ? fileAddr : peekAddr;

  always_comb
  begin
    memBus.wrEn = 1'b0;
    memBus.wrAddr = curAddr;
    memBus.wrData = memBus.rdData;
    // read-modify-write: byte fetched at accept, written back at end of execute
    if (state == bbx_pkg::ST_EXEC)
    begin
      if (curOp == bbx_pkg::OP_BIT_CLEAR)
      begin
        memBus.wrEn = 1'b1;
        memBus.wrData = memBus.rdData & ~bitMask;
      end
      if (curOp == bbx_pkg::OP_BIT_SET)
      begin
        memBus.wrEn = 1'b1;
        memBus.wrData = memBus.rdData | bitMask;
      end
    end
  end

  always_comb
  begin
    next_state = state;
    next_curOp = curOp;
    next_curAddr = curAddr;
    next_curBit = curBit;
    next_target = target;
    next_ready = ready;
    next_pcLoad = 1'b0;
    next_pcTarget = pcTarget;
    next_discardNext = 1'b0;
    case (state)
      bbx_pkg::ST_IDLE:
      begin
        if (accept)
        begin
          next_state = bbx_pkg::ST_EXEC;
          next_curOp = opKind;
          next_curAddr = fileAddr;
          next_curBit = bitSel;
          next_ready = 1'b0;
          if (opKind == bbx_pkg::OP_BRANCH_LIT)
            next_target = PC_WIDTH'(pcNext + litExt);
          else if (opKind == bbx_pkg::OP_BRANCH_WREG)
            next_target = PC_WIDTH'(pcNext + wregExt);
        end
      end
      bbx_pkg::ST_EXEC:
      begin
        next_state = bbx_pkg::ST_IDLE;
        next_ready = 1'b1;
        case (curOp)
          bbx_pkg::OP_SKIP_IF_CLEAR:
            next_discardNext = !testedBit;
          bbx_pkg::OP_SKIP_IF_SET:
            next_discardNext = testedBit;
          bbx_pkg::OP_BRANCH_LIT, bbx_pkg::OP_BRANCH_WREG:
          begin
            next_pcLoad = 1'b1;
            next_pcTarget = target;
            next_discardNext = 1'b1;
          end
          default:
            next_discardNext = 1'b0;
        endcase
      end
      default:
        next_state = bbx_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state <= bbx_pkg::ST_IDLE;
      curOp <= bbx_pkg::OP_BIT_CLEAR;
      curAddr <= '0;
      curBit <= '0;
      target <= bbx_pkg::RST_PC;
      ready <= bbx_pkg::RST_READY;
      pcLoad <= bbx_pkg::RST_PC_LOAD;
      pcTarget <= bbx_pkg::RST_PC;
      discardNext <= bbx_pkg::RST_DISCARD;
      statusWrEn <= 1'b0;
    end
    else
    begin
      state <= next_state;
      curOp <= next_curOp;
      curAddr <= next_curAddr;
      curBit <= next_curBit;
      target <= next_target;
      ready <= next_ready;
      pcLoad <= next_pcLoad;
      pcTarget <= next_pcTarget;
      discardNext <= next_discardNext;
      statusWrEn <= 1'b0;
    end
  end

  // observation path: refreshed only while idle, so an operand read never shows
  always_comb
  begin
    next_peekData = peekData;
    if (state == bbx_pkg::ST_IDLE && !accept)
      next_peekData = memBus.rdData;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      peekData <= bbx_pkg::RST_DATA;
    else
      peekData <= next_peekData;
  end
endmodule

/* hw/bbx_mem_if.sv */
// bbx_mem_if: register file access between execution unit and file memory
// assumes one clock shared by both ends
`timescale 1ns/100ps
interface bbx_mem_if;
  logic [bbx_pkg::FILE_AW-1:0] rdAddr;
  logic [bbx_pkg::DATA_W-1:0] rdData;
  logic wrEn;
  logic [bbx_pkg::FILE_AW-1:0] wrAddr;
  logic [bbx_pkg::DATA_W-1:0] wrData;
  modport ctrl (output rdAddr, output wrEn, output wrAddr, output wrData, input rdData);
  modport mem (input rdAddr, input wrEn, input wrAddr, input wrData, output rdData);
endinterface

/* hw/bbx_pkg.sv */
// bbx_pkg: constants shared by the bit and branch execution unit
// assumes a core with 7-bit file addressing and an 8-bit data path
package bbx_pkg;
  localparam int DATA_W = 8;
  localparam int FILE_AW = 7;
  localparam int FILE_DEPTH = 128;
  localparam int BIT_W = 3;
  localparam int LIT_W = 9;
  localparam int PC_W = 15;
  localparam int OP_W = 3;
  // operation codes from the decode stage
  localparam logic [2:0] OP_BIT_CLEAR = 3'h0;
  localparam logic [2:0] OP_BIT_SET = 3'h1;
  localparam logic [2:0] OP_SKIP_IF_CLEAR = 3'h2;
  localparam logic [2:0] OP_SKIP_IF_SET = 3'h3;
  localparam logic [2:0] OP_BRANCH_LIT = 3'h4;
  localparam logic [2:0] OP_BRANCH_WREG = 3'h5;
  // values after reset
  localparam logic RST_READY = 1'h1;
  localparam logic RST_PC_LOAD = 1'h0;
  localparam logic RST_DISCARD = 1'h0;
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [14:0] RST_PC = 15'h0000;
  // cycles per instruction of this group
  localparam int EXEC_CYCLES = 2;
  typedef enum logic [0:0] {ST_IDLE, ST_EXEC} bbx_state_e;
endpackage

/* hw/bbx_regfile.sv */
// bbx_regfile: 128 x 8 data memory, registered read, write-first not needed
// assumes reads and writes never target the same word in one cycle
`timescale 1ns/100ps
module bbx_regfile #(
  parameter int DEPTH = bbx_pkg::FILE_DEPTH
) (
  input wire logic clock,
  bbx_mem_if.mem port
);
  logic [bbx_pkg::DATA_W-1:0] store [DEPTH];
  logic [bbx_pkg::DATA_W-1:0] rdData;

  if (DEPTH > (1 << bbx_pkg::FILE_AW))
  begin : gDepthCheck
    $error("bbx_regfile: depth exceeds address range");
  end

  // no reset on storage: contents are unknown at power-up like real ram
  always_ff @(posedge clock)
  begin
    if (port.wrEn)
      store[port.wrAddr] <= port.wrData;
    rdData <= store[port.rdAddr];
  end

  assign port.rdData = rdData;
endmodule

/* test/bbx_exec_chk.sv */
// bbx_exec_chk: port-level assertions for the bit and branch unit
// assumes one clock and synchronous active-high reset
`timescale 1ns/100ps
module bbx_exec_chk #(
  parameter int PC_WIDTH = bbx_pkg::PC_W
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic opValid,
  input wire logic [2:0] opKind,
  input wire logic [6:0] fileAddr,
  input wire logic [2:0] bitSel,
  input wire logic [8:0] branchLit,
  input wire logic [7:0] wreg,
  input wire logic [PC_WIDTH-1:0] pcNext,
  input wire logic [6:0] peekAddr,
  input wire logic ready,
  input wire logic pcLoad,
  input wire logic [PC_WIDTH-1:0] pcTarget,
  input wire logic discardNext,
  input wire logic statusWrEn,
  input wire logic [7:0] peekData
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic acc;
  assign acc = opValid && ready;
  property p_busy; acc |=> !ready ##1 ready; endproperty
  property p_lit; acc && opKind == bbx_pkg::OP_BRANCH_LIT |-> ##2 pcLoad && discardNext
    && pcTarget == $past(pcNext, 2) + PC_WIDTH'($signed($past(branchLit, 2))); endproperty
  property p_wreg; acc && opKind == bbx_pkg::OP_BRANCH_WREG |-> ##2 pcLoad
    && pcTarget == $past(pcNext, 2) + PC_WIDTH'($past(wreg, 2)); endproperty
  property p_bit; acc && opKind <= 3'h1 |-> ##2 !pcLoad && !discardNext; endproperty
  property p_skip; acc && opKind inside {3'h2, 3'h3} |-> ##2 !pcLoad; endproperty
  property p_pulse; pcLoad |=> !pcLoad && !discardNext; endproperty
  property p_cause; pcLoad |-> !$past(ready); endproperty
  property p_flags; !statusWrEn; endproperty
  a_busy: assert property (p_busy) else $error("ready not low exactly one cycle");
  a_lit: assert property (p_lit) else $error("literal branch target wrong");
  a_wreg: assert property (p_wreg) else $error("wreg branch target wrong");
  a_bit: assert property (p_bit) else $error("bit op redirected flow");
  a_skip: assert property (p_skip) else $error("skip loaded pc");
  a_pulse: assert property (p_pulse) else $error("redirect pulse too long");
  a_cause: assert property (p_cause) else $error("pc load without execute cycle");
  a_flags: assert property (p_flags) else $error("status write seen");
  c_lit: cover property (acc && opKind == bbx_pkg::OP_BRANCH_LIT);
  c_wreg: cover property (acc && opKind == bbx_pkg::OP_BRANCH_WREG);
  c_skip: cover property (discardNext && !pcLoad);
endmodule
bind bbx_exec bbx_exec_chk #(.PC_WIDTH(PC_WIDTH)) chk (.clock, .rst, .opValid, .opKind, .fileAddr, .bitSel,
  .branchLit, .wreg, .pcNext, .peekAddr, .ready, .pcLoad, .pcTarget, .discardNext, .statusWrEn, .peekData);

/* test/tb_top.sv */
// tb_top: directed bench for the bit and branch unit
// assumes 2-cycle ops and 2-edge peek latency while idle
`timescale 1ns/100ps
module tb_top;
  logic clock = 0, rst = 1, opValid = 0, ready, pcLoad, discardNext, statusWrEn;
  logic [2:0] opKind = 0, bitSel = 0;
  logic [6:0] fileAddr = 0, peekAddr = 0;
  logic [8:0] branchLit = 0;
  logic [7:0] wreg = 0, peekData;
  logic [14:0] pcNext = 0, pcTarget;
  int nMismatch = 0, samplesChecked = 0;
  bbx_exec dut (.clock, .rst, .opValid, .opKind, .fileAddr, .bitSel, .branchLit, .wreg, .pcNext, .peekAddr,
    .ready, .pcLoad, .pcTarget, .discardNext, .statusWrEn, .peekData);
  initial forever #20 clock = ~clock;
  task chk(input string n, input logic [14:0] e, input logic [14:0] g);
    samplesChecked++;
    if (g !== e)
    begin
      nMismatch++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task wrapUp;
    if (nMismatch == 0 && samplesChecked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // one op; expects redirect pulse, discard and target
  task run(input logic [2:0] k, input logic [6:0] a, input logic [2:0] b, input logic [8:0] l,
    input logic [7:0] w, input logic [14:0] p, input logic eL, input logic eD, input logic [14:0] eT);
    {opKind, fileAddr, bitSel, branchLit, wreg, pcNext, opValid} = {k, a, b, l, w, p, 1'b1};
    @(posedge clock);
    #1 opValid = 0;
    chk("ready", 0, ready);
    @(posedge clock);
    #1 chk("ready", 1, ready);
    chk("pcLoad", eL, pcLoad);
    chk("discardNext", eD, discardNext);
    chk("statusWrEn", 0, statusWrEn);
    if (eL) chk("pcTarget", eT, pcTarget);
  endtask
  task peek(input logic [6:0] a, input logic [7:0] e);
    peekAddr = a;
    repeat (3) @(posedge clock);
    #1 chk("peekData", e, peekData);
  endtask
  task tBits;
    for (int i = 0; i < 8; i++)
    begin
      run(bbx_pkg::OP_BIT_SET, 7'h7F, 3'(i), 0, 0, 0, 0, 0, 0);
      run(bbx_pkg::OP_BIT_CLEAR, 7'h00, 3'(i), 0, 0, 0, 0, 0, 0);
    end
    peek(7'h7F, 8'hFF);
    peek(7'h00, 8'h00);
    run(bbx_pkg::OP_BIT_CLEAR, 7'h7F, 3'h7, 0, 0, 0, 0, 0, 0);
    peek(7'h7F, 8'h7F);
  endtask
  task tSkips;
    run(bbx_pkg::OP_SKIP_IF_CLEAR, 7'h7F, 3'h7, 0, 0, 0, 0, 1, 0);
    run(bbx_pkg::OP_SKIP_IF_CLEAR, 7'h7F, 3'h0, 0, 0, 0, 0, 0, 0);
    run(bbx_pkg::OP_SKIP_IF_SET, 7'h7F, 3'h7, 0, 0, 0, 0, 0, 0);
    run(bbx_pkg::OP_SKIP_IF_SET, 7'h7F, 3'h0, 0, 0, 0, 0, 1, 0);
  endtask
  task tBranches;
    run(bbx_pkg::OP_BRANCH_LIT, 0, 0, 9'h100, 0, 15'h0005, 1, 1, 15'h7F05);
    run(bbx_pkg::OP_BRANCH_LIT, 0, 0, 9'h0FF, 0, 15'h7FFF, 1, 1, 15'h00FE);
    run(bbx_pkg::OP_BRANCH_WREG, 0, 0, 0, 8'hFF, 15'h0010, 1, 1, 15'h010F);
    run(3'h6, 0, 0, 0, 0, 0, 0, 0, 0);
    chk("pcTarget", 15'h010F, pcTarget);
  endtask
  // watchdog so a stuck run still reports
  initial
  begin
    repeat (5000) @(posedge clock);
    nMismatch++;
    wrapUp;
  end
  initial
  begin
    repeat (20) @(posedge clock);
    #1 rst = 0;
    tBits;
    tSkips;
    tBranches;
    wrapUp;
  end
endmodule
